//--- core/sps_shifter.sv
// Eight-stage serial-in, parallel-out shift register with snapshot FIFO.
//
// What this block does
// - Eight stages, loaded serially at the first, all shown in parallel.
// - Clear low forces all stages low at once, regardless of clock or data.
// - Inputs are sampled and stages advance only on a rising shift clock.
// - A low on either serial gate input loads a low into stage one.
// - With one gate input high, stage one takes the other; an AND.
// - Each edge moves stages two to eight to the previous stage's old value.
`timescale 1ns/10ps
`default_nettype none

module sps_shifter #(
    parameter int STAGES = sps_pkg::STAGE_COUNT,
    parameter int DEPTH  = sps_pkg::FIFO_DEPTH
) (
    input  wire logic                                  mclk,
    input  wire logic                                  rst_b,
    input  wire logic                                  shiftClk,
    input  wire logic                                  serialGateInFirst,
    input  wire logic                                  serialGateInSecond,
    input  wire logic                                  clear_b,
    output logic      [STAGES-1:0]                     stageOut,
    output logic                                       stageOutFirst,
    output logic                                       stageOutLast,
    output logic      [sps_pkg::SHIFT_COUNT_BITS-1:0]  shiftCount,
    output logic      [STAGES-1:0]                     snapshotData,
    output logic                                       snapshotValid,
    input  wire logic                                  snapshotReady,
    output logic                                       captureReady,
    output logic                                       snapshotLost
);

    // ==========================================================
    // Clear release synchroniser
    // ==========================================================
    // Clear acts at once through the asynchronous reset of the stage
    // flops; only its release is brought onto mclk, so that no flop
    // leaves reset on an edge that is racing the clear pin.
    wire  clearOrReset_b;
    logic relSync1;
    logic relSync2;

    assign clearOrReset_b = rst_b & clear_b;

    always_ff @(posedge mclk or negedge clearOrReset_b) begin
        if (!clearOrReset_b) begin
            relSync1 <= 1'b0;
            relSync2 <= 1'b0;
        end else begin
            relSync1 <= 1'b1;
            relSync2 <= relSync1;
        end
    end

    wire stageRst_b;

    assign stageRst_b = relSync2;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // The shift clock and both gate inputs pass the same two flops,
    // so the data seen with a rising edge is the data that stood at
    // the pin when that edge was first sampled.
    logic clkSync1;
    logic clkSync2;
    logic gateASync1;
    logic gateASync2;
    logic gateBSync1;
    logic gateBSync2;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            clkSync1   <= 1'b0;
            clkSync2   <= 1'b0;
            gateASync1 <= 1'b0;
            gateASync2 <= 1'b0;
            gateBSync1 <= 1'b0;
            gateBSync2 <= 1'b0;
        end else begin
            clkSync1   <= shiftClk;
            clkSync2   <= clkSync1;
            gateASync1 <= serialGateInFirst;
            gateASync2 <= gateASync1;
            gateBSync1 <= serialGateInSecond;
            gateBSync2 <= gateBSync1;
        end
    end

    // ==========================================================
    // Rising-edge qualifier
    // ==========================================================
    // A high run of the synchronised shift clock is counted; one shift
    // fires when the run reaches the least pulse width, and never again
    // until the clock has gone low. Pulses shorter than one mclk period
    // may be missed entirely; the far side must respect that.
    logic [sps_pkg::RUN_COUNT_BITS-1:0] runCount;
    logic                               runDone;
    wire                                shiftEvent;

    assign shiftEvent = clkSync2 & ~runDone &
                        (runCount == sps_pkg::RUN_LIMIT);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            runCount <= sps_pkg::RUN_RESET;
            runDone  <= 1'b0;
        end else if (!clkSync2) begin
            runCount <= sps_pkg::RUN_RESET;
            runDone  <= 1'b0;
        end else if (shiftEvent) begin
            runDone  <= 1'b1;
        end else if (!runDone) begin
            runCount <= runCount + sps_pkg::RUN_STEP;
        end
    end

    // ==========================================================
    // Stage register
    // ==========================================================
    logic [STAGES-1:0] stage;
    logic [STAGES-1:0] next_stage;
    wire               newBit;

    // A low on either gate blocks the other; a high passes it.
    assign newBit = gateASync2 & gateBSync2;

    always_comb begin
        next_stage = stage;
        if (shiftEvent) begin
            next_stage = {stage[STAGES-2:0], newBit};
        end
    end

    always_ff @(posedge mclk or negedge stageRst_b) begin
        if (!stageRst_b) begin
            stage <= sps_pkg::STAGE_RESET;
        end else begin
            stage <= next_stage;
        end
    end

    // Every parallel output is the stage flop itself.
    assign stageOut      = stage;
    assign stageOutFirst = stage[0];
    assign stageOutLast  = stage[STAGES-1];

    // ==========================================================
    // Shift counter
    // ==========================================================
    // Counts accepted shifts since the last clear; it wraps silently.
    always_ff @(posedge mclk or negedge stageRst_b) begin
        if (!stageRst_b) begin
            shiftCount <= sps_pkg::COUNT_RESET;
        end else if (shiftEvent) begin
            shiftCount <= shiftCount + sps_pkg::COUNT_STEP;
        end
    end

    // ==========================================================
    // Snapshot capture
    // ==========================================================
    // The stage value after each shift is offered to the FIFO one
    // cycle later, when it is settled in the stage flops. The shift
    // clock cannot be stalled, so a full FIFO drops the snapshot and
    // raises the lost flag; captureReady warns the far side first.
    logic pushPending;
    wire  fifoInReady;
    wire  dropSnapshot;

    assign dropSnapshot = pushPending & ~fifoInReady;

    always_ff @(posedge mclk or negedge stageRst_b) begin
        if (!stageRst_b) begin
            pushPending  <= 1'b0;
            snapshotLost <= 1'b0;
        end else begin
            pushPending <= shiftEvent;
            if (dropSnapshot) begin
                snapshotLost <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Snapshot FIFO
    // ==========================================================
    sps_fifo #(
        .WIDTH (STAGES),
        .DEPTH (DEPTH)
    ) u_fifo (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .inData   (stage),
        .inValid  (pushPending),
        .inReady  (fifoInReady),
        .outData  (snapshotData),
        .outValid (snapshotValid),
        .outReady (snapshotReady)
    );

    assign captureReady = fifoInReady;

endmodule

`default_nettype wire

//--- core/sps_pkg.sv
// Shared constants of the serial-in, parallel-out shifter.
package sps_pkg;

    // ==========================================================
    // Geometry
    // ==========================================================
    localparam int STAGE_COUNT      = 8;
    localparam int FIFO_DEPTH       = 32;
    localparam int SHIFT_COUNT_BITS = 16;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [STAGE_COUNT-1:0]      STAGE_RESET = 8'h00;
    localparam logic [SHIFT_COUNT_BITS-1:0] COUNT_RESET = 16'h0000;
    localparam logic [SHIFT_COUNT_BITS-1:0] COUNT_STEP  = 16'h0001;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int MCLK_PERIOD_NS     = 100;
    localparam int MIN_CLK_PULSE_NS   = 20;
    localparam int MIN_CLEAR_PULSE_NS = 20;

    // Least times round up and never fall below one cycle.
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int MIN_CLK_PULSE_CYCLES = min_cycles(MIN_CLK_PULSE_NS);
    localparam int RUN_COUNT_BITS       = 4;
    localparam logic [RUN_COUNT_BITS-1:0] RUN_LIMIT =
        RUN_COUNT_BITS'(MIN_CLK_PULSE_CYCLES - 1);
    localparam logic [RUN_COUNT_BITS-1:0] RUN_STEP  = 4'h1;
    localparam logic [RUN_COUNT_BITS-1:0] RUN_RESET = 4'h0;

endpackage

//--- core/sps_fifo.sv
// Small synchronous FIFO with registered read data.
`timescale 1ns/10ps
`default_nettype none

module sps_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);

    localparam int PTR_BITS = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_BITS = $clog2(DEPTH + 1);
    localparam logic [CNT_BITS-1:0] CNT_FULL = CNT_BITS'(DEPTH);
    localparam logic [CNT_BITS-1:0] CNT_ONE  = CNT_BITS'(1);
    localparam logic [PTR_BITS-1:0] PTR_ONE  = PTR_BITS'(1);
    localparam logic [PTR_BITS-1:0] PTR_LAST = PTR_BITS'(DEPTH - 1);

    // ==========================================================
    // Storage and pointers
    // ==========================================================
    logic [WIDTH-1:0]    mem [DEPTH];
    logic [PTR_BITS-1:0] wrPtr;
    logic [PTR_BITS-1:0] rdPtr;
    logic [CNT_BITS-1:0] count;
    logic [CNT_BITS-1:0] next_count;
    wire                 push;
    wire                 pop;

    assign push = inValid & inReady;
    // The output register refills whenever a word is stored and the register is empty or being taken.
    assign pop  = (count != '0) & (~outValid | outReady);

    always_comb begin
        next_count = count;
        if (push & ~pop) begin
            next_count = count + CNT_ONE;
        end else if (pop & ~push) begin
            next_count = count - CNT_ONE;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr    <= '0;
            rdPtr    <= '0;
            count    <= '0;
            inReady  <= 1'b1;
            outValid <= 1'b0;
            outData  <= '0;
        end else begin
            count   <= next_count;
            inReady <= (next_count != CNT_FULL);
            if (push) begin
                wrPtr <= (wrPtr == PTR_LAST) ? '0 : wrPtr + PTR_ONE;
            end
            if (pop) begin
                rdPtr    <= (rdPtr == PTR_LAST) ? '0 : rdPtr + PTR_ONE;
                outData  <= mem[rdPtr];
                outValid <= 1'b1;
            end else if (outReady) begin
                outValid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

//--- verif/sps_shifter_chk.sv
// Assertions on the pins of the serial-in, parallel-out shifter.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Checker
// ==========================================================
module sps_shifter_chk #(
    parameter int STAGES = 8
) (
    input wire logic                                 mclk,
    input wire logic                                 rst_b,
    input wire logic                                 shiftClk,
    input wire logic                                 serialGateInFirst,
    input wire logic                                 serialGateInSecond,
    input wire logic                                 clear_b,
    input wire logic [STAGES-1:0]                    stageOut,
    input wire logic                                 stageOutFirst,
    input wire logic                                 stageOutLast,
    input wire logic [sps_pkg::SHIFT_COUNT_BITS-1:0] shiftCount,
    input wire logic [STAGES-1:0]                    snapshotData,
    input wire logic                                 snapshotValid,
    input wire logic                                 snapshotReady,
    input wire logic                                 captureReady,
    input wire logic                                 snapshotLost
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // A rise counts only after clear has been high long enough to settle.
    sequence s_armed;
        clear_b[*4] ##0 !shiftClk;
    endsequence
    sequence s_shift;
        s_armed ##1 (shiftClk && clear_b);
    endsequence

    property p_mirror;
        stageOutFirst == stageOut[0] && stageOutLast == stageOut[STAGES-1];
    endproperty
    property p_clear;
        !clear_b |-> stageOut == '0 && shiftCount == '0;
    endproperty
    property p_edge;
        clear_b[*4] ##0 !$stable(stageOut)
            |-> $past(shiftClk, 3) && !$past(shiftClk, 4);
    endproperty
    property p_low;
        s_shift ##0 !(serialGateInFirst && serialGateInSecond)
            |-> ##3 (!clear_b || !stageOut[0]);
    endproperty
    property p_high;
        s_shift ##0 (serialGateInFirst && serialGateInSecond)
            |-> ##3 (!clear_b || stageOut[0]);
    endproperty
    property p_move;
        s_shift |-> ##3
            (!clear_b || stageOut[STAGES-1:1] == $past(stageOut[STAGES-2:0]));
    endproperty
    property p_count;
        s_shift |-> ##3 (!clear_b || shiftCount == $past(shiftCount) + 16'h0001);
    endproperty
    property p_hold;
        (clear_b && $stable(shiftClk))[*5] |-> $stable(stageOut);
    endproperty

    a_mirror: assert property (p_mirror) else $error("pin mirror wrong");
    a_clear: assert property (p_clear) else $error("clear not held");
    a_edge: assert property (p_edge) else $error("change off edge");
    a_low: assert property (p_low) else $error("first not low");
    a_high: assert property (p_high) else $error("first not high");
    a_move: assert property (p_move) else $error("stages not moved");
    a_count: assert property (p_count) else $error("count wrong");
    a_hold: assert property (p_hold) else $error("stages drifted");
endmodule

bind sps_shifter sps_shifter_chk #(.STAGES(STAGES)) i_chk (
    .mclk, .rst_b, .shiftClk, .serialGateInFirst, .serialGateInSecond,
    .clear_b, .stageOut, .stageOutFirst, .stageOutLast, .shiftCount,
    .snapshotData, .snapshotValid, .snapshotReady, .captureReady,
    .snapshotLost
);
`default_nettype wire

//--- verif/sps_link_model.sv
// Logic that drives the shifter's gates, shift clock and clear.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Link driver
// ==========================================================
module sps_link_model (
    input  wire logic mclk,
    output var  logic shiftClk,
    output var  logic gateFirst,
    output var  logic gateSecond,
    output var  logic clear_b
);
    initial begin
        shiftClk = 1'b0;
        gateFirst = 1'b0;
        gateSecond = 1'b0;
        clear_b = 1'b1;
    end

    task automatic shift(input logic a, input logic b, input int hi);
        @(posedge mclk);
        gateFirst <= a;
        gateSecond <= b;
        @(posedge mclk);
        shiftClk <= 1'b1;
        @(posedge mclk);
        @(posedge mclk);
        // Gates move while the clock is high, as a real source may do.
        gateFirst <= ~a;
        gateSecond <= ~b;
        repeat (hi) @(posedge mclk);
        shiftClk <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wiggle(input int n);
        repeat (n) begin
            @(posedge mclk);
            gateFirst <= ~gateFirst;
            gateSecond <= gateFirst;
        end
    endtask

    task automatic setClear(input logic v);
        @(posedge mclk);
        clear_b <= v;
    endtask
endmodule
`default_nettype wire

//--- verif/sps_shifter_bench.sv
// Self-checking bench for the serial-in, parallel-out shifter.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Bench
// ==========================================================
module sps_shifter_bench;
    logic        mclk;
    logic        rst_b;
    logic        snapshotReady;
    wire logic   shiftClk, gateFirst, gateSecond, clear_b;
    logic [7:0]  stageOut, snapshotData, expStage;
    logic        stageOutFirst, stageOutLast, snapshotValid;
    logic        captureReady, snapshotLost;
    logic [15:0] shiftCount;
    logic [7:0]  expQ[$];
    int          n_mismatch = 0;
    int          n_tests = 0;

    sps_link_model i_link (.mclk(mclk), .shiftClk(shiftClk),
        .gateFirst(gateFirst), .gateSecond(gateSecond), .clear_b(clear_b));
    sps_shifter i_dut (.mclk(mclk), .rst_b(rst_b), .shiftClk(shiftClk),
        .serialGateInFirst(gateFirst), .serialGateInSecond(gateSecond),
        .clear_b(clear_b), .stageOut(stageOut), .stageOutFirst(stageOutFirst),
        .stageOutLast(stageOutLast), .shiftCount(shiftCount),
        .snapshotData(snapshotData), .snapshotValid(snapshotValid),
        .snapshotReady(snapshotReady), .captureReady(captureReady),
        .snapshotLost(snapshotLost));

    task automatic report_and_stop();
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic step(input logic a, input logic b, input int hi);
        i_link.shift(a, b, hi);
        expStage = {expStage[6:0], a & b};
        check({stageOutLast, stageOutFirst, stageOut},
              {expStage[7], expStage[0], expStage});
    endtask

    task automatic t_gates();
        expStage = 8'h00;
        for (int i = 0; i < 12; i++) begin
            step(i[0], i[1] | i[2], (i == 5) ? 6 : 1);
        end
        check(shiftCount, 16'h000c);
        i_link.wiggle(12);
        check(stageOut, expStage);
    endtask

    task automatic t_clear();
        step(1'b1, 1'b1, 1);
        i_link.setClear(1'b0);
        #1;
        check({shiftCount, stageOut}, 24'h000000);
        i_link.shift(1'b1, 1'b1, 1);
        check(stageOut, 8'h00);
        i_link.setClear(1'b1);
        repeat (3) @(posedge mclk);
        expStage = 8'h00;
    endtask

    // The consumer stalls until the buffer refuses, then drains it all.
    task automatic t_fifo();
        @(posedge mclk);
        snapshotReady <= 1'b0;
        for (int i = 0; i < 34; i++) begin
            step(1'b1, i[0] | i[2], 1);
            if (i < 33)
                expQ.push_back(expStage);
        end
        // The drop is flagged on the edge at which the last step returns.
        @(negedge mclk);
        check({captureReady, snapshotLost}, 2'b01);
        @(posedge mclk);
        snapshotReady <= 1'b1;
        for (int i = 0; i < 33; i++) begin
            @(negedge mclk);
            check({snapshotValid, snapshotData},
                  {1'b1, expQ.pop_front()});
        end
        @(negedge mclk);
        check({snapshotValid, captureReady, snapshotLost}, 3'b011);
        i_link.setClear(1'b0);
        #1;
        check(snapshotLost, 1'b0);
        i_link.setClear(1'b1);
    endtask

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        rst_b = 1'b0;
        snapshotReady = 1'b1;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        t_gates();
        t_clear();
        t_fifo();
        report_and_stop();
    end
endmodule
`default_nettype wire
